// ===== logic/hbp_pkg.sv
package hbp_pkg;

  // register map of the host port
  localparam logic [8:0] IRQ_SUMMARY_ADDR = 9'h003;
  localparam logic [8:0] IRQ_MASK_BASE    = 9'h010;
  localparam logic [8:0] IRQ_LATCH_BASE   = 9'h018;
  localparam logic [7:0] MASK_RESET       = 8'h00;
  localparam logic [7:0] LATCH_RESET      = 8'h00;
  localparam logic [7:0] SUMMARY_RESET    = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA    = 8'h00;
  localparam int         MAX_GROUPS       = 8;

  // host timing limits, in MHz
  localparam int SYNC_CLK_MAX_MHZ   = 36;
  localparam int ASYNC_INT_MHZ      = 32;
  localparam int ASYNC_MUX_HOST_MHZ = 16;
  localparam int ASYNC_SEP_HOST_MHZ = 30;

  // bus style select values
  localparam logic STYLE_SEPARATE = 1'b0;
  localparam logic STYLE_MUXED    = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } hbp_state_e;

  // host control strobes; meaning of each but chip select depends on the bus style
  typedef struct packed {
    logic csN;       // chip select, both styles
    logic asAle;     // address strobe (low) or address latch enable (high)
    logic dsRdN;     // data strobe or read strobe, low active
    logic rwWrN;     // read/write direction (1 = read) or write strobe
  } hbp_ctl_s;

  // mode straps of the port
  typedef struct packed {
    logic busStyleSelect;
    logic syncModeSelect;
    logic clockSourceSelect;
  } hbp_mode_s;

  // every pin that crosses into the ref_clk domain
  typedef struct packed {
    hbp_ctl_s   ctl;
    hbp_mode_s  mode;
    logic [8:0] addr;
    logic [7:0] ad;
    logic       portClk;
    logic       irqLineN;
  } hbp_pins_s;

endpackage

// ===== logic/hbp_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser for a bundle of level signals
module hbp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // bundle
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } hbp_sync_s;

  hbp_sync_s state_r;
  hbp_sync_s state_nxt;

  if (W < 1)
  begin
    $error("hbp_sync: width must be at least 1");
  end

  always_comb
  begin
    state_nxt.meta   = d;
    state_nxt.stable = state_r.meta;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign q = state_r.stable;

endmodule

`default_nettype wire

// ===== logic/hbp_port.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - separate style: register address comes from the nine address lines
// - muxed style: address is top address line plus shared bus, latched
// - data bytes use the shared bus; device drives it only during reads
// - style low: chip select, address strobe, read/write, data strobe
// - style high: chip select, address latch enable, read and write strobes
// - style high: low address bits are multiplexed on the shared bus
// - sync mode select: transfers are sampled on port clock edges
// - async modes: sync select and clock source both 0, internal clock
// - sync modes: sync select and clock source both 1, external clock
// - async port runs at 32 MHz; hosts limited to 16 or 30 MHz
// - interrupt request pin is active low open drain, wire-or capable
// - all sources share one request pin, each individually enabled
// - mask bit 1 permits, 0 blocks; all mask bits reset to 0
// - event latches capture events regardless of the mask
// - latched bits clear only when the host reads that latch register
// - summary register shows each active group as a high bit
// - reading the summary clears bits of groups no longer active; writing it does nothing
module hbp_port #(
  parameter int GROUPS = 4
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // host pins, asynchronous to ref_clk
  input  wire hbp_pkg::hbp_ctl_s     hostCtl,
  input  wire hbp_pkg::hbp_mode_s    hostMode,
  input  wire logic                  portClk,
  input  wire logic [8:0]            addrIn,
  // shared address/data bus
  input  wire logic [7:0]            adIn,
  output logic      [7:0]            adOut,
  output logic                       adOe,
  // open-drain interrupt request
  input  wire logic                  intReqInN,
  output logic                       intReqOutN,
  output logic                       intReqOe,
  // interrupt events from the device core, one bus per group
  input  wire logic [GROUPS-1:0][7:0] eventIn
);

  typedef struct packed {
    hbp_pkg::hbp_state_e   st;
    logic                  clkPrev;
    logic [8:0]            addrLat;
    logic [GROUPS-1:0][7:0] mask;
    logic [GROUPS-1:0][7:0] latch;
    logic [7:0]            summ;
    logic [7:0]            rdData;
    logic                  adOe;
    logic                  reqN;
  } hbp_port_s;

  hbp_port_s         state_r;
  hbp_port_s         state_nxt;
  hbp_pkg::hbp_pins_s pinsRaw;
  hbp_pkg::hbp_pins_s pinsS;
  logic              useExt;
  logic              step;
  logic              rdReq;
  logic              wrReq;
  logic [8:0]        accAddr;
  logic [GROUPS-1:0] clrLat;
  logic              clrSum;
  logic [GROUPS-1:0] groupActive;

  // elaboration-time refusal of group counts the register map cannot hold
  if (GROUPS < 1 || GROUPS > hbp_pkg::MAX_GROUPS)
  begin
    $error("hbp_port: GROUPS must be 1..8");
  end

  assign pinsRaw = '{ctl: hostCtl, mode: hostMode, addr: addrIn, ad: adIn,
                     portClk: portClk, irqLineN: intReqInN};

  hbp_sync #(
    .W ($bits(hbp_pkg::hbp_pins_s))
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       (pinsRaw),
    .q       (pinsS)
  );

  // read mux over the register map
  function automatic logic [7:0] readMux(input hbp_port_s s, input logic [8:0] a);
    logic [7:0] v;
    v = hbp_pkg::UNMAPPED_DATA;
    if (a == hbp_pkg::IRQ_SUMMARY_ADDR)
      v = s.summ;
    for (int g = 0; g < GROUPS; g++)
    begin
      if (a == hbp_pkg::IRQ_MASK_BASE + 9'(g))
        v = s.mask[g];
      if (a == hbp_pkg::IRQ_LATCH_BASE + 9'(g))
        v = s.latch[g];
    end
    return v;
  endfunction

  always_comb
  begin
    state_nxt = state_r;
    // external clock when sync mode or external clock source is strapped
    useExt = pinsS.mode.syncModeSelect | pinsS.mode.clockSourceSelect;
    step   = useExt ? (pinsS.portClk & ~state_r.clkPrev) : 1'b1;
    state_nxt.clkPrev = pinsS.portClk;
    if (pinsS.mode.busStyleSelect == hbp_pkg::STYLE_MUXED)
    begin
      rdReq   = ~pinsS.ctl.csN & ~pinsS.ctl.dsRdN;
      wrReq   = ~pinsS.ctl.csN & ~pinsS.ctl.rwWrN;
      accAddr = state_r.addrLat;
      if (step && pinsS.ctl.asAle)
        state_nxt.addrLat = {pinsS.addr[8], pinsS.ad};
    end
    else
    begin
      rdReq   = ~pinsS.ctl.csN & ~pinsS.ctl.asAle & ~pinsS.ctl.dsRdN & pinsS.ctl.rwWrN;
      wrReq   = ~pinsS.ctl.csN & ~pinsS.ctl.asAle & ~pinsS.ctl.dsRdN & ~pinsS.ctl.rwWrN;
      accAddr = pinsS.addr;
    end
    clrLat = '0;
    clrSum = 1'b0;
    case (state_r.st)
      hbp_pkg::ST_IDLE:
      begin
        if (step && rdReq)
        begin
          state_nxt.rdData = readMux(state_r, accAddr);
          state_nxt.adOe   = 1'b1;
          state_nxt.st     = hbp_pkg::ST_READ;
          clrSum = (accAddr == hbp_pkg::IRQ_SUMMARY_ADDR);
          for (int g = 0; g < GROUPS; g++)
            clrLat[g] = (accAddr == hbp_pkg::IRQ_LATCH_BASE + 9'(g));
        end
        else if (step && wrReq)
        begin
          // only the masks are writable; summary and latches ignore writes
          for (int g = 0; g < GROUPS; g++)
            if (accAddr == hbp_pkg::IRQ_MASK_BASE + 9'(g))
              state_nxt.mask[g] = pinsS.ad;
          state_nxt.st = hbp_pkg::ST_WRITE;
        end
      end
      hbp_pkg::ST_READ:
      begin
        if (step && !rdReq)
        begin
          state_nxt.adOe = 1'b0;
          state_nxt.st   = hbp_pkg::ST_IDLE;
        end
      end
      hbp_pkg::ST_WRITE:
      begin
        if (step && !wrReq)
          state_nxt.st = hbp_pkg::ST_IDLE;
      end
      default:
      begin
        state_nxt.adOe = 1'b0;
        state_nxt.st   = hbp_pkg::ST_IDLE;
      end
    endcase
    // events set regardless of mask; a set in the clearing cycle wins
    for (int g = 0; g < GROUPS; g++)
    begin
      state_nxt.latch[g] = (clrLat[g] ? 8'h00 : state_r.latch[g]) | eventIn[g];
      groupActive[g]     = |(state_r.latch[g] & state_r.mask[g]);
    end
    state_nxt.summ = clrSum ? 8'h00 : state_r.summ;
    state_nxt.summ[GROUPS-1:0] = state_nxt.summ[GROUPS-1:0] | groupActive;
    state_nxt.reqN = 1'b1;
    for (int g = 0; g < GROUPS; g++)
      if (|(state_nxt.latch[g] & state_nxt.mask[g]))
        state_nxt.reqN = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r         <= '0;
      state_r.st      <= hbp_pkg::ST_IDLE;
      state_r.mask    <= {GROUPS{hbp_pkg::MASK_RESET}};
      state_r.latch   <= {GROUPS{hbp_pkg::LATCH_RESET}};
      state_r.summ    <= hbp_pkg::SUMMARY_RESET;
      state_r.reqN    <= 1'b1;
    end
    else
      state_r <= state_nxt;
  end

  // open drain: output value is always low, enable pulls the line
  assign adOut      = state_r.rdData;
  assign adOe       = state_r.adOe;
  assign intReqOutN = state_r.reqN & 1'b0;
  assign intReqOe   = ~state_r.reqN;

  chk_rd_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
    adOe |-> state_r.st == hbp_pkg::ST_READ)
    else $error("shared bus driven outside a read");

  chk_rd_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_r.st == hbp_pkg::ST_READ && step && !rdReq) |=> !adOe ##1 !adOe)
    else $error("shared bus not released after read strobe");

  chk_event_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (eventIn[0] != 8'h00) |=> ((state_r.latch[0] & $past(eventIn[0])) == $past(eventIn[0])))
    else $error("event not latched");

  chk_latch_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((state_r.latch[0] & ~state_nxt.latch[0]) != 8'h00) |-> clrLat[0])
    else $error("latched bit dropped without a read");

  chk_sum_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clrSum && groupActive == '0) |=> state_r.summ == 8'h00)
    else $error("summary not cleared by read");

  chk_irq_assert: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (groupActive != '0) |-> (intReqOe && !intReqOutN))
    else $error("request not driven for enabled event");

  chk_irq_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (groupActive == '0) |-> !intReqOe)
    else $error("request driven with nothing enabled");

  chk_sep_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_r.st == hbp_pkg::ST_IDLE && step && rdReq && !pinsS.mode.busStyleSelect
     && pinsS.addr == hbp_pkg::IRQ_SUMMARY_ADDR) |=> adOut == $past(state_r.summ))
    else $error("separate-style read returned wrong data");

  chk_mux_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pinsS.mode.busStyleSelect && step && pinsS.ctl.asAle)
    |=> state_r.addrLat == {$past(pinsS.addr[8]), $past(pinsS.ad)})
    else $error("muxed address not latched");

  chk_sync_sample: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (useExt && !step) |=> $stable(state_r.st))
    else $error("state moved without a port clock edge");

  // host bus: takes, data path and write effects
  chk_async_take: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!useExt && state_r.st == hbp_pkg::ST_IDLE && rdReq) |=> adOe)
    else $error("async read not answered in one cycle");

  chk_sync_take: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (useExt && step && state_r.st == hbp_pkg::ST_IDLE && rdReq) |=> adOe)
    else $error("sync read not answered after port clock edge");

  chk_rd_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_r.st == hbp_pkg::ST_IDLE && step && rdReq && accAddr == hbp_pkg::IRQ_MASK_BASE)
    |=> adOut == $past(state_r.mask[0]))
    else $error("mask read returned wrong data");

  chk_mask_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_r.st == hbp_pkg::ST_IDLE && step && !rdReq && wrReq
     && accAddr == hbp_pkg::IRQ_MASK_BASE) |=> state_r.mask[0] == $past(pinsS.ad))
    else $error("mask write did not land");

  chk_addr_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pinsS.mode.busStyleSelect && !pinsS.ctl.asAle) |=> $stable(state_r.addrLat))
    else $error("muxed address moved without address latch enable");

  // interrupt side: latches and summary
  chk_latch_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clrLat[0] && eventIn[0] == 8'h00) |=> state_r.latch[0] == 8'h00)
    else $error("latch not cleared by read");

  chk_latch_nowrite: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_r.st == hbp_pkg::ST_IDLE && step && !rdReq && wrReq)
    |=> (state_r.latch[0] & $past(state_r.latch[0])) == $past(state_r.latch[0]))
    else $error("write disturbed a latch");

  chk_sum_nowrite: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_r.st == hbp_pkg::ST_IDLE && step && !rdReq && wrReq)
    |=> (state_r.summ & $past(state_r.summ)) == $past(state_r.summ))
    else $error("write disturbed the summary");

  chk_sum_reflect: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (groupActive != '0)
    |=> (state_r.summ[GROUPS-1:0] & $past(groupActive)) == $past(groupActive))
    else $error("active group missing from summary");

  cov_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_r.st == hbp_pkg::ST_READ ##1 state_r.st == hbp_pkg::ST_IDLE);

  cov_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_r.st == hbp_pkg::ST_WRITE);

  cov_irq_line: cover property (@(posedge ref_clk) disable iff (!rst_n)
    intReqOe && !pinsS.irqLineN);

  cov_sync_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
    useExt && state_r.st == hbp_pkg::ST_READ);

  cov_mux_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
    pinsS.mode.busStyleSelect && state_r.st == hbp_pkg::ST_WRITE);

endmodule

`default_nettype wire

// ===== testbench/hbp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// byte-wide host processor driving the port's pins
module hbp_host_model (
  // clock
  input  wire logic              ref_clk,
  // host pins
  output var  hbp_pkg::hbp_ctl_s  hostCtl,
  output var  hbp_pkg::hbp_mode_s hostMode,
  output logic                   portClk,
  output logic [8:0]             addrIn,
  output logic [7:0]             adIn,
  // device answers and the shared request wire
  input  wire logic [7:0]        adOut,
  input  wire logic              adOe,
  input  wire logic              intReqOe,
  output logic                   intReqInN
);
  logic [7:0] hostD;
  logic       hostDrv;
  logic [7:0] floatD = 8'h5A;

  // undriven bus shows a changing pattern, never the last value
  always @(posedge ref_clk) floatD <= ~floatD;
  assign adIn = adOe ? adOut : (hostDrv ? hostD : floatD);
  // pulled-up wire, low while the device sinks it
  assign intReqInN = ~intReqOe;

  initial
  begin
    hostCtl = 4'hF;
    hostMode = 3'b000;
    addrIn = 9'h000;
    hostD = 8'h00;
    hostDrv = 1'b0;
    portClk = 1'b0;
    #37;
    // 160 ns port clock, free running, below the sync ceiling
    forever #80 portClk = ~portClk;
  end

  task automatic setMode(input logic [2:0] m);
    @(posedge ref_clk);
    hostMode <= m;
    hostCtl <= {1'b1, ~m[2], 2'b11};
    repeat (8) @(posedge ref_clk);
  endtask

  // one register access; bad flags device driving outside a read or a read left unanswered
  task automatic acc(input logic wr, input logic [8:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic bad);
    int n;
    int k;
    n = hostMode.syncModeSelect ? 64 : 4;
    bad = 1'b0;
    k = 0;
    @(posedge ref_clk);
    if (hostMode.busStyleSelect)
    begin
      // address phase on the shared bus; low address lines carry junk
      hostCtl <= 4'h7;
      addrIn <= {a[8], ~a[7:0]};
      hostD <= a[7:0];
      hostDrv <= 1'b1;
      repeat (n) @(posedge ref_clk);
      hostCtl.asAle <= 1'b0;
      @(posedge ref_clk);
      hostCtl.dsRdN <= wr;
      hostCtl.rwWrN <= ~wr;
    end
    else
    begin
      hostCtl <= {3'b000, ~wr};
      addrIn <= a;
    end
    hostD <= d;
    hostDrv <= wr;
    repeat (n)
    begin
      @(posedge ref_clk);
      if (wr && adOe !== 1'b0) bad = 1'b1;
    end
    while (!wr && adOe !== 1'b1 && k < 200)
    begin
      @(posedge ref_clk);
      k++;
    end
    q = adOut;
    if (!wr && adOe !== 1'b1) bad = 1'b1;
    hostCtl <= {1'b1, ~hostMode.busStyleSelect, 2'b11};
    hostDrv <= 1'b0;
    repeat (n + 2) @(posedge ref_clk);
    if (adOe !== 1'b0) bad = 1'b1;
  endtask
endmodule

`default_nettype wire

// ===== testbench/hbp_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
  begin nChecks++; if ((got) !== (exp)) begin numErrors++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end

module hbp_port_tb;
  localparam int G = 4;
  logic               ref_clk = 1'b0;
  logic               rst_n = 1'b0;
  hbp_pkg::hbp_ctl_s  hostCtl;
  hbp_pkg::hbp_mode_s hostMode;
  logic               portClk;
  logic [8:0]         addrIn;
  logic [7:0]         adIn;
  logic [7:0]         adOut;
  logic               adOe;
  logic               intReqInN;
  logic               intReqOutN;
  logic               intReqOe;
  logic [G-1:0][7:0]  eventIn = '0;
  int                 numErrors = 0;
  int                 nChecks = 0;
  int                 cycles = 0;
  logic [7:0]         q;
  logic               bad;

  always #5 ref_clk = ~ref_clk;

  hbp_port #(.GROUPS(G)) hbp_port_i (.ref_clk(ref_clk), .rst_n(rst_n), .hostCtl(hostCtl),
    .hostMode(hostMode), .portClk(portClk), .addrIn(addrIn), .adIn(adIn), .adOut(adOut),
    .adOe(adOe), .intReqInN(intReqInN), .intReqOutN(intReqOutN), .intReqOe(intReqOe),
    .eventIn(eventIn));

  hbp_host_model hbp_host_model_i (.ref_clk(ref_clk), .hostCtl(hostCtl), .hostMode(hostMode),
    .portClk(portClk), .addrIn(addrIn), .adIn(adIn), .adOut(adOut), .adOe(adOe),
    .intReqOe(intReqOe), .intReqInN(intReqInN));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic rdChk(input logic [8:0] a, input logic [7:0] e);
    hbp_host_model_i.acc(1'b0, a, 8'h00, q, bad);
    `CHK(q, e)
    `CHK(bad, 1'b0)
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    hbp_host_model_i.acc(1'b1, a, d, q, bad);
    `CHK(bad, 1'b0)
  endtask

  task automatic pulse(input int g, input logic [7:0] v);
    @(posedge ref_clk);
    eventIn[g] <= v;
    @(posedge ref_clk);
    eventIn[g] <= 8'h00;
    repeat (2) @(posedge ref_clk);
  endtask

  // hang guard: the whole run needs under a thousand cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      numErrors++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int g = 0; g < G; g++)
    begin
      rdChk(hbp_pkg::IRQ_MASK_BASE + 9'(g), hbp_pkg::MASK_RESET);
      rdChk(hbp_pkg::IRQ_LATCH_BASE + 9'(g), hbp_pkg::LATCH_RESET);
    end
    rdChk(hbp_pkg::IRQ_SUMMARY_ADDR, hbp_pkg::SUMMARY_RESET);
    $display("test reset values done");
    for (int g = 0; g < G; g++)
      wr(hbp_pkg::IRQ_MASK_BASE + 9'(g), 8'hA5 ^ 8'(g));
    wr(9'h110, 8'h3C);
    for (int g = 0; g < G; g++)
      rdChk(hbp_pkg::IRQ_MASK_BASE + 9'(g), 8'hA5 ^ 8'(g));
    rdChk(9'h110, hbp_pkg::UNMAPPED_DATA);
    $display("test mask access done");
    wr(hbp_pkg::IRQ_MASK_BASE, 8'h0F);
    pulse(0, 8'hF0);
    `CHK(intReqOe, 1'b0)
    rdChk(hbp_pkg::IRQ_LATCH_BASE, 8'hF0);
    rdChk(hbp_pkg::IRQ_LATCH_BASE, 8'h00);
    rdChk(hbp_pkg::IRQ_SUMMARY_ADDR, 8'h00);
    $display("test blocked event done");
    pulse(2, 8'h81);
    `CHK(intReqOe, 1'b1)
    `CHK(intReqOutN, 1'b0)
    `CHK(intReqInN, 1'b0)
    wr(hbp_pkg::IRQ_LATCH_BASE + 9'h002, 8'h00);
    rdChk(hbp_pkg::IRQ_SUMMARY_ADDR, 8'h04);
    rdChk(hbp_pkg::IRQ_LATCH_BASE + 9'h002, 8'h81);
    `CHK(intReqOe, 1'b0)
    wr(hbp_pkg::IRQ_SUMMARY_ADDR, 8'hFF);
    rdChk(hbp_pkg::IRQ_SUMMARY_ADDR, 8'h04);
    rdChk(hbp_pkg::IRQ_SUMMARY_ADDR, 8'h00);
    $display("test enabled event done");
    hbp_host_model_i.setMode(3'b100);
    wr(hbp_pkg::IRQ_MASK_BASE + 9'h001, 8'h5E);
    wr(9'h111, 8'h77);
    rdChk(hbp_pkg::IRQ_MASK_BASE + 9'h001, 8'h5E);
    $display("test muxed style done");
    hbp_host_model_i.setMode(3'b011);
    wr(hbp_pkg::IRQ_MASK_BASE + 9'h003, 8'hC3);
    rdChk(hbp_pkg::IRQ_MASK_BASE + 9'h003, 8'hC3);
    hbp_host_model_i.setMode(3'b111);
    rdChk(hbp_pkg::IRQ_MASK_BASE + 9'h003, 8'hC3);
    $display("test sync modes done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
